// file: design/flash_status_reg.sv
// two-byte status register of a serial flash with its spi read and write paths
//
// Contract
// [RULE1] status read accepted any time, also while busy
// [RULE2] host asserts chip select then shifts read-status opcode
// [RULE3] after opcode, one status bit per clock, no dummy cycles
// [RULE4] byte one, byte two, then repeat while selected and clocked
// [RULE5] every repeated pass carries freshly sampled status
// [RULE6] ready/busy in bit 0 of both bytes, refreshed per byte
// [RULE7] above read limit first two bytes invalid; host reads four or more
// [RULE8] chip select high ends read and floats serial output at once
// [RULE9] byte one bit 7 is writable protection lock, 0 after power-up
// [RULE10] reserved bits read-only zero
// [RULE11] byte one bit 5 is read-only erase/program error flag
// [RULE12] byte one bit 4 reads 0 while write-protect pin asserted
// [RULE13] byte one bits 3:2 report software protection, default 11
// [RULE14] byte one bit 1 is read-only write enable latch, default 0
// [RULE15] bit 0 reads 1 while busy, 0 when ready
// [RULE16] byte two bit 4 is writable soft reset enable, default 0
// [RULE17] byte two bit 3 is writable lockdown enable, default 0
// [RULE18] first write-status command changes only byte one bit 7
// [RULE19] second write-status command changes only byte two bits 4 and 3
// [RULE20] lock set blocks sector protect/unprotect and global protect
// [RULE21] lock cleared at power-up, untouched by soft reset
// [RULE22] with write-protect asserted lock may only go from 0 to 1
// [RULE23] host writes byte one as opcode plus one data byte
// [RULE24] clearing lock under write-protect is ignored and clears latch
`timescale 1ns/10ps
module flash_status_reg
	import flash_status_pkg::*;
(
	// system
	input wire logic clk,
	input wire logic arst_n,
	// spi link
	input wire logic spi_sck,
	input wire logic cs_n,
	input wire logic si,
	output logic so,
	output logic so_oe,
	// write-protect pin, active low
	input wire logic wprot_n,
	// status from the program and erase engine
	input wire logic ready_busy_flag,
	input wire logic erase_program_error,
	input wire logic [1:0] soft_protect_status,
	input wire logic wel_clear,
	input wire logic freeze_lockdown,
	// command gating
	input wire logic sector_cmd_req,
	output logic sector_cmd_grant,
	input wire logic soft_reset_req,
	output logic soft_reset_do,
	output logic global_prot_req,
	output logic [3:0] global_prot_code,
	// control levels
	output logic protect_regs_lock,
	output logic write_enable_latch,
	output logic soft_reset_enable,
	output logic lockdown_enable
);

	// ---- spi domain ----
	logic frame_rst;
	logic [4:0] cnt_r;
	logic [4:0] cnt_nxt;
	logic [7:0] in_sh_r;
	logic [7:0] opc_w;
	frame_phase_t phase_r;
	frame_phase_t phase_nxt;
	logic [7:0] op_cap_r;
	logic [7:0] dat_cap_r;
	logic [4:0] bits_cap_r;
	logic seq_r;
	logic [15:0] st_meta_r;
	logic [15:0] st_sync_r;
	logic [7:0] out_byte_r;
	logic [7:0] sel_byte;
	logic [2:0] bit_idx;
	logic so_r;
	logic so_oe_r;
	logic rd_active;

	// chip select high holds the frame logic cleared
	assign frame_rst = cs_n | ~arst_n;
	// past two bytes the count wraps by sixteen so byte parity and alignment survive
	assign cnt_nxt = (cnt_r == CNT_MAX) ? CNT_CMD_BITS : cnt_r + 5'h01;
	assign opc_w = {in_sh_r[6:0], si};

	always_comb begin
		phase_nxt = phase_r;
		case (phase_r)
			PH_OPCODE: begin
				if (cnt_r == CNT_OPC_LAST) begin
					if (opc_w == OP_READ_STATUS) begin
						phase_nxt = PH_STATUS; // [RULE1]
					end else if (opc_w == OP_WRITE_STAT1 || opc_w == OP_WRITE_STAT2) begin
						phase_nxt = PH_DATA;
					end else begin
						phase_nxt = PH_IGNORE;
					end
				end
			end
			PH_STATUS: phase_nxt = PH_STATUS;
			PH_DATA: phase_nxt = PH_DATA;
			PH_IGNORE: phase_nxt = PH_IGNORE;
			default: phase_nxt = PH_OPCODE;
		endcase
	end

	always_ff @(posedge spi_sck or posedge frame_rst) begin
		if (frame_rst) begin
			cnt_r <= 5'h00;
			in_sh_r <= 8'h00;
			phase_r <= PH_OPCODE;
		end else begin
			cnt_r <= cnt_nxt;
			in_sh_r <= opc_w;
			phase_r <= phase_nxt;
		end
	end

	// captured command survives chip select rising; the system side reads it
	// only after the link clock has stopped, so it is quasi-static there
	always_ff @(posedge spi_sck or negedge arst_n) begin
		if (!arst_n) begin
			op_cap_r <= 8'h00;
			dat_cap_r <= 8'h00;
			bits_cap_r <= 5'h00;
			seq_r <= 1'b0;
		end else begin
			bits_cap_r <= cnt_nxt;
			if (cnt_r == 5'h00) begin
				seq_r <= ~seq_r;
			end
			if (cnt_r == CNT_OPC_LAST) begin
				op_cap_r <= opc_w;
			end
			if (cnt_r == CNT_DAT_LAST) begin
				dat_cap_r <= opc_w; // [RULE23]
			end
		end
	end

	// status bits are independent levels, so per-bit synchronising is enough
	logic [7:0] stat1_r;
	logic [7:0] stat2_r;
	always_ff @(posedge spi_sck or negedge arst_n) begin
		if (!arst_n) begin
			st_meta_r <= {RST_STAT1, RST_STAT2};
			st_sync_r <= {RST_STAT1, RST_STAT2};
		end else begin
			st_meta_r <= {stat1_r, stat2_r};
			st_sync_r <= st_meta_r; // [RULE5]
		end
	end

	assign rd_active = (phase_r == PH_STATUS);
	assign bit_idx = cnt_r[2:0];
	// odd byte slots carry byte one, even ones byte two
	assign sel_byte = cnt_r[3] ? st_sync_r[15:8] : st_sync_r[7:0]; // [RULE4]

	// output changes on the falling edge so the host samples on the rising one
	always_ff @(negedge spi_sck or posedge frame_rst) begin
		if (frame_rst) begin
			out_byte_r <= 8'h00;
			so_r <= 1'b0;
			so_oe_r <= 1'b0;
		end else begin
			so_oe_r <= rd_active; // [RULE3]
			if (rd_active && bit_idx == 3'h0) begin
				out_byte_r <= sel_byte; // [RULE6]
				so_r <= sel_byte[7];
			end else if (rd_active) begin
				so_r <= out_byte_r[3'h7 - bit_idx];
			end
		end
	end

	assign so = so_r;
	// the pin itself cuts the drive without waiting for any edge
	assign so_oe = so_oe_r & ~cs_n; // [RULE8]

	// ---- system domain ----
	logic cs_meta_r;
	logic cs_sync_r;
	logic cs_prev_r;
	logic seq_meta_r;
	logic seq_sync_r;
	logic seq_seen_r;
	logic wp_meta_r;
	logic wp_sync_r;
	logic lock_r;
	logic lock_nxt;
	logic wel_r;
	logic wel_nxt;
	logic soft_reset_enable_r;
	logic soft_reset_enable_nxt;
	logic sle_r;
	logic sle_nxt;
	logic frozen_r;
	logic glb_req_r;
	logic [3:0] glb_code_r;
	logic srst_r;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cs_meta_r <= 1'b1;
			cs_sync_r <= 1'b1;
			cs_prev_r <= 1'b1;
			seq_meta_r <= 1'b0;
			seq_sync_r <= 1'b0;
			seq_seen_r <= 1'b0;
			wp_meta_r <= 1'b1;
			wp_sync_r <= 1'b1;
		end else begin
			cs_meta_r <= cs_n;
			cs_sync_r <= cs_meta_r;
			cs_prev_r <= cs_sync_r;
			seq_meta_r <= seq_r;
			seq_sync_r <= seq_meta_r;
			wp_meta_r <= wprot_n;
			wp_sync_r <= wp_meta_r;
			if (cs_sync_r && !cs_prev_r) begin
				seq_seen_r <= seq_sync_r;
			end
		end
	end

	// a frame counts only if it saw at least one clock edge
	logic frame_end;
	logic wp_asserted;
	logic op_full;
	logic op_only;
	logic with_data;
	logic is_wsr1;
	logic is_wsr2;
	logic wsr1_ok;
	logic wsr2_ok;
	logic wel_set;
	logic wel_clr;

	assign frame_end = cs_sync_r & ~cs_prev_r & (seq_sync_r != seq_seen_r);
	assign wp_asserted = ~wp_sync_r;
	assign op_full = (bits_cap_r >= CNT_OPC_BITS);
	assign op_only = (bits_cap_r == CNT_OPC_BITS);
	assign with_data = (bits_cap_r >= CNT_CMD_BITS) && (bits_cap_r[2:0] == 3'h0);
	assign is_wsr1 = op_full && (op_cap_r == OP_WRITE_STAT1);
	assign is_wsr2 = op_full && (op_cap_r == OP_WRITE_STAT2);
	// an attempt to unlock while write-protect is asserted is dropped whole
	assign wsr1_ok = frame_end && is_wsr1 && with_data && wel_r
		&& !(wp_asserted && lock_r && !dat_cap_r[7]); // [RULE22] [RULE24]
	assign wsr2_ok = frame_end && is_wsr2 && with_data && wel_r;
	assign wel_set = frame_end && op_only && (op_cap_r == OP_WRITE_EN);
	assign wel_clr = (frame_end && (is_wsr1 || is_wsr2)) // [RULE24]
		|| (frame_end && op_only && (op_cap_r == OP_WRITE_DIS))
		|| wel_clear || srst_r;

	assign lock_nxt = wsr1_ok ? dat_cap_r[7] : lock_r; // [RULE18] [RULE9]
	assign soft_reset_enable_nxt = wsr2_ok ? dat_cap_r[B2_SOFT_RESET_ENABLE] : soft_reset_enable_r; // [RULE19] [RULE16]
	// freezing lockdown holds the enable at zero for good
	assign sle_nxt = (freeze_lockdown || frozen_r) ? 1'b0
		: (wsr2_ok ? dat_cap_r[B2_SLE] : sle_r); // [RULE17]
	// a set arriving with a clear wins
	assign wel_nxt = wel_set ? 1'b1 : (wel_clr ? 1'b0 : wel_r);

	// power-up resets these; soft reset leaves lock, soft_reset_enable and sle alone but clears wel_r
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			lock_r <= RST_LOCK; // [RULE21]
			wel_r <= RST_WEL;
			soft_reset_enable_r <= RST_SOFT_RESET_ENABLE;
			sle_r <= RST_SLE;
			frozen_r <= 1'b0;
		end else begin
			lock_r <= lock_nxt;
			wel_r <= wel_nxt;
			soft_reset_enable_r <= soft_reset_enable_nxt;
			sle_r <= sle_nxt;
			frozen_r <= frozen_r | freeze_lockdown;
		end
	end

	// global protect judged on the lock value before this write
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			glb_req_r <= 1'b0;
			glb_code_r <= 4'h0;
			srst_r <= 1'b0;
		end else begin
			glb_req_r <= wsr1_ok && !lock_r; // [RULE20]
			if (wsr1_ok) begin
				glb_code_r <= dat_cap_r[GLB_LO +: 4];
			end
			srst_r <= soft_reset_req && soft_reset_enable_r;
		end
	end

	// status bytes rebuilt every cycle so each byte shifted out is current
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			stat1_r <= RST_STAT1;
			stat2_r <= RST_STAT2;
		end else begin
			stat1_r[B1_LOCK] <= lock_r;
			stat1_r[6] <= 1'b0; // [RULE10]
			stat1_r[B1_EPE] <= erase_program_error; // [RULE11]
			stat1_r[B1_WPP] <= wp_sync_r; // [RULE12]
			stat1_r[B1_SWP_LO +: 2] <= soft_protect_status; // [RULE13]
			stat1_r[B1_WEL] <= wel_r; // [RULE14]
			stat1_r[B_BUSY] <= ready_busy_flag; // [RULE15]
			stat2_r[7:5] <= 3'h0; // [RULE10]
			stat2_r[B2_SOFT_RESET_ENABLE] <= soft_reset_enable_r;
			stat2_r[B2_SLE] <= sle_r;
			stat2_r[2:1] <= 2'h0;
			stat2_r[B_BUSY] <= ready_busy_flag; // [RULE6]
		end
	end

	assign sector_cmd_grant = sector_cmd_req & ~lock_r; // [RULE20]
	assign soft_reset_do = srst_r;
	assign global_prot_req = glb_req_r;
	assign global_prot_code = glb_code_r;
	assign protect_regs_lock = lock_r;
	assign write_enable_latch = wel_r;
	assign soft_reset_enable = soft_reset_enable_r;
	assign lockdown_enable = sle_r;

endmodule

// file: design/flash_status_pkg.sv
// constants and types shared by the flash status register block
package flash_status_pkg;
	// opcodes
	localparam logic [7:0] OP_READ_STATUS = 8'h05;
	localparam logic [7:0] OP_WRITE_STAT1 = 8'h01;
	localparam logic [7:0] OP_WRITE_STAT2 = 8'h31;
	localparam logic [7:0] OP_WRITE_EN = 8'h06;
	localparam logic [7:0] OP_WRITE_DIS = 8'h04;

	// status byte one field positions
	localparam int B1_LOCK = 7;
	localparam int B1_EPE = 5;
	localparam int B1_WPP = 4;
	localparam int B1_SWP_LO = 2;
	localparam int B1_WEL = 1;
	localparam int B_BUSY = 0;
	// status byte two field positions
	localparam int B2_SOFT_RESET_ENABLE = 4;
	localparam int B2_SLE = 3;
	// write byte one global protect code field
	localparam int GLB_LO = 2;

	// values after reset
	localparam logic RST_LOCK = 1'b0;
	localparam logic RST_WEL = 1'b0;
	localparam logic RST_SOFT_RESET_ENABLE = 1'b0;
	localparam logic RST_SLE = 1'b0;
	localparam logic [7:0] RST_STAT1 = 8'h0c;
	localparam logic [7:0] RST_STAT2 = 8'h00;

	// bit counts within a frame
	localparam logic [4:0] CNT_OPC_LAST = 5'h07;
	localparam logic [4:0] CNT_DAT_LAST = 5'h0f;
	localparam logic [4:0] CNT_OPC_BITS = 5'h08;
	localparam logic [4:0] CNT_CMD_BITS = 5'h10;
	localparam logic [4:0] CNT_MAX = 5'h1f;

	typedef enum logic [3:0] {
		PH_OPCODE = 4'b0001,
		PH_STATUS = 4'b0010,
		PH_DATA = 4'b0100,
		PH_IGNORE = 4'b1000
	} frame_phase_t;
endpackage

// file: dv/flash_status_checker.sv
// port assertions for the flash status register
`timescale 1ns/10ps
module flash_status_checker (
	// system
	input wire logic clk,
	input wire logic arst_n,
	// link and pin
	input wire logic cs_n,
	input wire logic so_oe,
	input wire logic wprot_n,
	// gating and levels
	input wire logic sector_cmd_req,
	input wire logic sector_cmd_grant,
	input wire logic soft_reset_req,
	input wire logic soft_reset_do,
	input wire logic global_prot_req,
	input wire logic protect_regs_lock,
	input wire logic write_enable_latch,
	input wire logic soft_reset_enable
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	// long enough for the pin synchroniser to have settled
	sequence wp_held;
		(!wprot_n) [*6];
	endsequence
	sequence srst_go;
		soft_reset_req && soft_reset_enable;
	endsequence
	a_float_deselect: assert property (cs_n |-> !so_oe)
		else $error("so driven while deselected");
	a_grant_lock: assert property (sector_cmd_grant == (sector_cmd_req && !protect_regs_lock))
		else $error("sector grant wrong for lock");
	a_wp_no_unlock: assert property (wp_held |=> !$fell(protect_regs_lock))
		else $error("lock cleared under write protect");
	a_lock_wel_low: assert property ($changed(protect_regs_lock) |-> !write_enable_latch)
		else $error("latch left set by status write");
	a_srst_fires: assert property (srst_go |=> soft_reset_do)
		else $error("enabled soft reset not issued");
	a_srst_quiet: assert property (!soft_reset_req |=> !soft_reset_do)
		else $error("soft reset without request");
	a_srst_keep: assert property (soft_reset_do |=> $stable(protect_regs_lock) && $stable(soft_reset_enable))
		else $error("soft reset changed lock or enable");
	a_glob_unlocked: assert property (global_prot_req |-> !$past(protect_regs_lock, 2))
		else $error("global protect while locked");
endmodule
bind flash_status_reg flash_status_checker flash_status_checker_inst (.clk, .arst_n, .cs_n,
	.so_oe, .wprot_n, .sector_cmd_req, .sector_cmd_grant, .soft_reset_req, .soft_reset_do,
	.global_prot_req, .protect_regs_lock, .write_enable_latch, .soft_reset_enable);

// file: dv/spi_host_model.sv
// spi host model issuing status read and write frames
`timescale 1ns/10ps
module spi_host_model (
	// spi link
	output logic spi_sck,
	output logic cs_n,
	output logic si,
	input wire logic so
);
	initial begin
		spi_sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end
	// mode 0, clock stands low between frames, msb first
	task automatic xfer(input logic [15:0] tx, input int nbits, output logic [63:0] rx);
		rx = '0;
		#7;
		cs_n = 1'b0;
		for (int i = 0; i < nbits; i++) begin
			si = (i < 16) ? tx[15 - i] : ~si;
			#80;
			spi_sck = 1'b1;
			rx = {rx[62:0], so};
			#80;
			spi_sck = 1'b0;
		end
		#80;
		cs_n = 1'b1;
		// released line must not keep its last value
		si = ~si;
		#400;
	endtask
endmodule

// file: dv/tb_top.sv
// self-checking bench for the flash status register
`timescale 1ns/10ps
module tb_top
	import flash_status_pkg::*;
;
	logic clk, arst_n, spi_sck, cs_n, si, so, so_oe, wprot_n, ready_busy_flag;
	logic erase_program_error, sector_cmd_req, soft_reset_req, sector_cmd_grant;
	logic soft_reset_do, global_prot_req, protect_regs_lock, write_enable_latch;
	logic soft_reset_enable, lockdown_enable;
	logic wel_clear, freeze_lockdown;
	logic [1:0] soft_protect_status;
	logic [3:0] global_prot_code;
	logic [63:0] rx;
	int bad_count = 0;
	int tests_run = 0;
	int cycles = 0;
	flash_status_reg flash_status_reg_inst (.clk, .arst_n, .spi_sck, .cs_n, .si, .so, .so_oe,
		.wprot_n, .ready_busy_flag, .erase_program_error, .soft_protect_status,
		.wel_clear, .freeze_lockdown, .sector_cmd_req, .sector_cmd_grant,
		.soft_reset_req, .soft_reset_do, .global_prot_req, .global_prot_code,
		.protect_regs_lock, .write_enable_latch, .soft_reset_enable, .lockdown_enable);
	spi_host_model spi_host_model_inst (.spi_sck, .cs_n, .si, .so);
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			bad_count++;
			summarize();
		end
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic frame(input logic [7:0] op, input logic [7:0] dat, input int nbits);
		spi_host_model_inst.xfer({op, dat}, nbits, rx);
	endtask
	task automatic wr(input logic [7:0] op, input logic [7:0] dat);
		frame(OP_WRITE_EN, 8'h00, 8);
		frame(op, dat, 24);
	endtask
	task automatic pulse_reset();
		@(negedge clk) soft_reset_req = 1'b1;
		@(negedge clk) soft_reset_req = 1'b0;
	endtask
	initial begin
		arst_n = 1'b0;
		wprot_n = 1'b1;
		ready_busy_flag = 1'b1;
		erase_program_error = 1'b1;
		soft_protect_status = 2'b11;
		sector_cmd_req = 1'b1;
		soft_reset_req = 1'b0;
		wel_clear = 1'b0;
		freeze_lockdown = 1'b0;
		repeat (8) @(posedge clk);
		@(negedge clk) arst_n = 1'b1;
		repeat (4) @(negedge clk);
		check("levels", 8'h00, {4'h0, protect_regs_lock, write_enable_latch,
			soft_reset_enable, lockdown_enable});
		// status moves while the read is running, mid fourth byte
		fork
			frame(OP_READ_STATUS, 8'h00, 56);
			begin
				#5600;
				@(negedge clk);
				ready_busy_flag = 1'b0;
				erase_program_error = 1'b0;
				soft_protect_status = 2'b01;
			end
		join
		check("busy b1", 8'h3d, rx[31:24]);
		check("busy b2", 8'h01, rx[23:16]);
		check("new b1", 8'h14, rx[15:8]);
		check("new b2", 8'h00, rx[7:0]);
		frame(OP_WRITE_EN, 8'h00, 8);
		frame(OP_READ_STATUS, 8'h00, 24);
		check("wel b1", 8'h16, rx[15:8]);
		pulse_reset();
		frame(OP_WRITE_STAT1, 8'hff, 24);
		check("lock wel", 8'h02, {6'h0, protect_regs_lock, write_enable_latch});
		check("grant lk", 8'h00, {7'h0, sector_cmd_grant});
		check("glob code", 8'h0f, {4'h0, global_prot_code});
		frame(OP_READ_STATUS, 8'h00, 24);
		check("lock b1", 8'h94, rx[15:8]);
		@(negedge clk) wprot_n = 1'b0;
		wr(OP_WRITE_STAT1, 8'h00);
		check("wp lock", 8'h02, {6'h0, protect_regs_lock, write_enable_latch});
		frame(OP_READ_STATUS, 8'h00, 24);
		check("wp b1", 8'h84, rx[15:8]);
		@(negedge clk) wprot_n = 1'b1;
		wr(OP_WRITE_STAT1, 8'h00);
		check("unlock", 8'h00, {6'h0, protect_regs_lock, write_enable_latch});
		check("grant ul", 8'h01, {7'h0, sector_cmd_grant});
		wr(OP_WRITE_STAT2, 8'hff);
		check("en levels", 8'h03, {6'h0, soft_reset_enable, lockdown_enable});
		frame(OP_READ_STATUS, 8'h00, 24);
		check("en b2", 8'h18, rx[7:0]);
		wr(OP_WRITE_STAT1, 8'h80);
		frame(OP_WRITE_EN, 8'h00, 8);
		pulse_reset();
		repeat (6) @(negedge clk);
		check("srst lock", 8'h02, {6'h0, protect_regs_lock, write_enable_latch});
		check("srst en", 8'h03, {6'h0, soft_reset_enable, lockdown_enable});
		// engine finishing an operation drops the latch
		frame(OP_WRITE_EN, 8'h00, 8);
		check("wel set", 8'h01, {7'h0, write_enable_latch});
		@(negedge clk) wel_clear = 1'b1;
		@(negedge clk) wel_clear = 1'b0;
		@(negedge clk);
		check("wel clr", 8'h00, {7'h0, write_enable_latch});
		// a frozen lockdown keeps its enable at zero, reset enable untouched
		@(negedge clk) freeze_lockdown = 1'b1;
		@(negedge clk) freeze_lockdown = 1'b0;
		@(negedge clk);
		check("frozen", 8'h02, {6'h0, soft_reset_enable, lockdown_enable});
		wr(OP_WRITE_STAT2, 8'hff);
		check("frz keep", 8'h02, {6'h0, soft_reset_enable, lockdown_enable});
		// deselect part way through a byte
		frame(OP_READ_STATUS, 8'h00, 12);
		check("float", 8'h00, {7'h0, so_oe});
		summarize();
	end
endmodule
